// ==== rtl/packet_filter_line_balance_select_codec.sv ====
// frame filter, checksum and line codec with a shared payload buffer
// assumes config inputs are static during a frame; lineRxChip is asynchronous
`timescale 1ns/10ps
`default_nettype none
module packet_filter_line_balance_select_codec #(
  parameter int DEPTH      = pkt_pkg::BUF_DEPTH,
  parameter int SYNC_BYTES = pkt_pkg::SYNC_BYTES
) (
  input  wire logic                       ref_clk,
  input  wire logic                       sys_rst,
  input  wire pkt_pkg::frame_cfg_t        frameConfig,
  input  wire logic [8*SYNC_BYTES-1:0]    syncPatternBytes,
  input  wire logic [15:0]                symbolRateSetting,
  input  wire logic [$clog2(DEPTH+1)-1:0] levelThreshold,
  input  wire logic                       txStart,
  input  wire logic                       rxEnable,
  input  wire logic [7:0]                 hostWrData,
  input  wire logic                       hostWrValid,
  output logic                            hostWrReady,
  input  wire logic                       hostRdReq,
  output logic [7:0]                      hostRdData,
  output logic                            hostRdStrobe,
  input  wire logic                       lineRxChip,
  output logic                            lineTxChip,
  output logic                            lineTxActive,
  output pkt_pkg::flags_t                 statusFlags
);
  localparam int SW = 8 * SYNC_BYTES;        // sync bits
  localparam int CW = $clog2(DEPTH + 1);     // buffer count width

  logic [7:0]    mem [0:DEPTH-1];            // payload buffer storage
  pkt_pkg::eng_state_t state_r, state_nxt;   // frame engine state
  logic [15:0]   divCnt_r, divCnt_nxt;       // chip period divider
  logic          rxMeta_r, rxBit_r;          // receive pin synchroniser
  logic [7:0]    shReg_r, shReg_nxt;         // current byte shifter
  logic [5:0]    bitCnt_r, bitCnt_nxt;       // bit counter
  logic [8:0]    byteCnt_r, byteCnt_nxt;     // payload byte counter
  logic [8:0]    frameLen_r, frameLen_nxt;   // expected payload bytes
  logic [15:0]   crc_r, crc_nxt;             // running checksum
  logic [15:0]   crcRx_r, crcRx_nxt;         // received checksum bits
  logic [8:0]    lfsr_r, lfsr_nxt;           // whitening sequence
  logic          phase_r, phase_nxt;         // manchester half bit
  logic          firstChip_r, firstChip_nxt; // first received half bit
  logic [SW-1:0] syncSh_r, syncSh_nxt;       // sync shift register
  logic          txChip_r, txChip_nxt;       // line output chip
  logic          txAct_r, txAct_nxt;         // transmitter busy
  logic          txDone_r, txDone_nxt;       // done pulse
  logic          ready_r, ready_nxt;         // frame ready pulse
  logic          match_r, match_nxt;         // frame match pulse
  logic          pass_r, pass_nxt;           // last check result
  logic [CW-1:0] rdPtr_r, rdPtr_nxt, wrPtr_r, wrPtr_nxt, count_r, count_nxt;
  logic [7:0]    rdData_r, rdData_nxt;       // host read data
  logic          rdStb_r, rdStb_nxt;         // host read strobe
  // per-cycle work values
  logic          tick, manch, whit, addrOn, isVar, coded, bitIn, dBit, step;
  logic          pushEn, popEn, clr;
  logic [7:0]    pushData, rxByte, headByte;
  logic [8:0]    len9;
  logic [SW-1:0] syncNext;
  logic          syncHit, addrEvt, addrHit, lenEvt, lenBad, crcEvt, crcPass;

  // one checksum step, msb first
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
    crcStep = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? pkt_pkg::CRC_POLY : 16'h0000);
  endfunction : crcStep

  // receive pin synchroniser
  always_ff @(posedge ref_clk) begin
    rxMeta_r <= lineRxChip;
    rxBit_r  <= rxMeta_r;
  end

  // buffer storage write
  always_ff @(posedge ref_clk) begin
    if (pushEn && !clr) begin
      mem[wrPtr_r] <= pushData;
    end
  end

  // next state of engine and buffer
  always_comb begin
    state_nxt = state_r;  shReg_nxt = shReg_r;  bitCnt_nxt = bitCnt_r;
    byteCnt_nxt = byteCnt_r;  frameLen_nxt = frameLen_r;  crc_nxt = crc_r;
    crcRx_nxt = crcRx_r;  lfsr_nxt = lfsr_r;  phase_nxt = phase_r;
    firstChip_nxt = firstChip_r;  syncSh_nxt = syncSh_r;  txChip_nxt = txChip_r;
    txAct_nxt = txAct_r;  pass_nxt = pass_r;  rdData_nxt = rdData_r;
    txDone_nxt = 1'b0;  ready_nxt = 1'b0;  match_nxt = 1'b0;  rdStb_nxt = 1'b0;
    pushEn = 1'b0;  popEn = 1'b0;  clr = 1'b0;  pushData = hostWrData;
    syncHit = 1'b0;  addrEvt = 1'b0;  addrHit = 1'b0;  lenEvt = 1'b0;
    lenBad = 1'b0;  crcEvt = 1'b0;  crcPass = 1'b0;
    tick = (divCnt_r == symbolRateSetting);  // chip rate same in sync and payload
    divCnt_nxt = tick ? 16'h0000 : divCnt_r + 16'h0001;
    manch = (frameConfig.lineBalanceSelect == pkt_pkg::BAL_MANCH);
    whit = (frameConfig.lineBalanceSelect == pkt_pkg::BAL_WHITEN);
    addrOn = (frameConfig.addrFilterSelect == pkt_pkg::ADDR_OWN) ||
             (frameConfig.addrFilterSelect == pkt_pkg::ADDR_GROUP);
    isVar = (frameConfig.frameFormat == pkt_pkg::FMT_VAR);
    headByte = (count_r == '0) ? 8'h00 : mem[rdPtr_r];
    coded = shReg_r[7] ^ (whit & lfsr_r[0]);
    bitIn = manch ? firstChip_r : rxBit_r;              // first chip carries the bit
    dBit = bitIn ^ (whit & lfsr_r[0]);
    step = !manch || phase_r;
    rxByte = {shReg_r[6:0], dBit};
    len9 = frameLen_r;  // expected bytes; receive reloads it from the length byte
    syncNext = {syncSh_r[SW-2:0], rxBit_r};
    case (state_r)
      pkt_pkg::S_IDLE: begin
        if (txStart) begin
          state_nxt = pkt_pkg::S_TXSYNC;  syncSh_nxt = syncPatternBytes;
          bitCnt_nxt = '0;  txAct_nxt = 1'b1;
        end else if (rxEnable) begin
          state_nxt = pkt_pkg::S_HUNT;  syncSh_nxt = '0;  // cannot match: no zero byte
        end
      end
      pkt_pkg::S_TXSYNC: if (tick) begin
        txChip_nxt = syncSh_r[SW-1];                   // sync sent uncoded
        syncSh_nxt = {syncSh_r[SW-2:0], 1'b0};
        bitCnt_nxt = bitCnt_r + 6'h01;
        if (bitCnt_r == 6'(SW - 1)) begin
          state_nxt = pkt_pkg::S_TXDATA;  shReg_nxt = headByte;  popEn = (count_r != '0);
          bitCnt_nxt = '0;  byteCnt_nxt = '0;  phase_nxt = 1'b0;
          crc_nxt = pkt_pkg::CRC_PRESET;  lfsr_nxt = pkt_pkg::WHITEN_SEED;
          // length taken from the head byte now, before shifting destroys it
          frameLen_nxt = isVar ? {1'b0, headByte} + 9'h001 :  // length byte loads counter
                         {1'b0, frameConfig.maxFrameLength};
        end
      end
      pkt_pkg::S_TXDATA, pkt_pkg::S_TXCRC: if (tick) begin
        txChip_nxt = (manch && phase_r) ? !coded : coded;  // one as 10, zero as 01
        phase_nxt = manch && !phase_r;
        if (step) begin
          lfsr_nxt = {lfsr_r[0] ^ lfsr_r[pkt_pkg::WHITEN_TAP], lfsr_r[8:1]};
          shReg_nxt = {shReg_r[6:0], 1'b0};
          bitCnt_nxt = bitCnt_r + 6'h01;
          if (state_r == pkt_pkg::S_TXDATA) begin
            crc_nxt = crcStep(crc_r, shReg_r[7]);
            if (bitCnt_r[2:0] == 3'h7) begin
              byteCnt_nxt = byteCnt_r + 9'h001;
              if ((frameConfig.frameFormat == pkt_pkg::FMT_UNLIM) ? (count_r == '0)
                  : (byteCnt_r + 9'h001 == len9)) begin
                if (frameConfig.checkEnable) begin
                  state_nxt = pkt_pkg::S_TXCRC;  bitCnt_nxt = '0;
                  shReg_nxt = ~crc_nxt[15:8];          // inverted checksum appended
                end else begin
                  state_nxt = pkt_pkg::S_TXEND;
                end
              end else begin
                shReg_nxt = headByte;  popEn = (count_r != '0);
              end
            end
          end else if (bitCnt_r[2:0] == 3'h7) begin
            if (!bitCnt_r[3]) begin
              shReg_nxt = ~crc_r[7:0];
            end else begin
              state_nxt = pkt_pkg::S_TXEND;
            end
          end
        end
      end
      pkt_pkg::S_TXEND: if (tick) begin
        txDone_nxt = 1'b1;  txAct_nxt = 1'b0;          // last chip has held a full period
        state_nxt = pkt_pkg::S_IDLE;
      end
      pkt_pkg::S_HUNT: begin
        if (!rxEnable) begin
          state_nxt = pkt_pkg::S_IDLE;
        end else if (tick) begin
          syncSh_nxt = syncNext;
          if (syncNext == syncPatternBytes) begin      // no match: nothing flagged
            syncHit = 1'b1;  state_nxt = pkt_pkg::S_RXDATA;
            match_nxt = !addrOn;
            bitCnt_nxt = '0;  byteCnt_nxt = '0;  phase_nxt = 1'b0;
            crc_nxt = pkt_pkg::CRC_PRESET;  lfsr_nxt = pkt_pkg::WHITEN_SEED;
            frameLen_nxt = (frameConfig.frameFormat == pkt_pkg::FMT_FIXED) ?
                           {1'b0, frameConfig.maxFrameLength} : 9'h000;
          end
        end
      end
      default: begin  // receive payload and checksum
        if (!rxEnable) begin
          state_nxt = pkt_pkg::S_IDLE;
        end else if (tick && manch && !phase_r) begin
          firstChip_nxt = rxBit_r;  phase_nxt = 1'b1;
        end else if (tick) begin
          phase_nxt = 1'b0;
          lfsr_nxt = {lfsr_r[0] ^ lfsr_r[pkt_pkg::WHITEN_TAP], lfsr_r[8:1]};
          shReg_nxt = rxByte;
          bitCnt_nxt = bitCnt_r + 6'h01;
          if (state_r == pkt_pkg::S_RXDATA) begin
            crc_nxt = crcStep(crc_r, dBit);
            if (bitCnt_r[2:0] == 3'h7) begin
              byteCnt_nxt = byteCnt_r + 9'h001;
              lenEvt = (byteCnt_r == 9'h000) && isVar;
              lenBad = lenEvt && (rxByte >= frameConfig.maxFrameLength);
              len9 = lenEvt ? {1'b0, rxByte} + 9'h001 : frameLen_r;
              frameLen_nxt = len9;
              addrEvt = addrOn && (byteCnt_r == (isVar ? 9'h001 : 9'h000));
              addrHit = (rxByte == frameConfig.ownStationId) ||
                        (frameConfig.addrFilterSelect == pkt_pkg::ADDR_GROUP &&
                         rxByte == frameConfig.groupStationId);
              match_nxt = addrEvt && addrHit;
              if (lenBad || (addrEvt && !addrHit)) begin
                clr = 1'b1;  state_nxt = pkt_pkg::S_HUNT;  syncSh_nxt = '0;
              end else begin
                pushEn = (count_r != CW'(DEPTH));      // address and length kept
                pushData = rxByte;
                if (frameConfig.frameFormat != pkt_pkg::FMT_UNLIM &&
                    byteCnt_r + 9'h001 == len9) begin
                  bitCnt_nxt = '0;
                  if (frameConfig.checkEnable) begin
                    state_nxt = pkt_pkg::S_RXCRC;
                  end else begin
                    ready_nxt = 1'b1;  state_nxt = pkt_pkg::S_HUNT;  syncSh_nxt = '0;
                  end
                end
              end
            end
          end else begin
            crcRx_nxt = {crcRx_r[14:0], dBit};         // checksum never buffered
            if (bitCnt_r[3:0] == 4'hf) begin
              crcEvt = 1'b1;
              crcPass = (crcRx_nxt == ~crc_r);
              pass_nxt = crcPass;
              ready_nxt = crcPass || frameConfig.keepOnCheckFail;
              clr = !ready_nxt;
              state_nxt = pkt_pkg::S_HUNT;  syncSh_nxt = '0;
            end
          end
        end
      end
    endcase
    // host side: writes outside receive, reads outside transmit
    hostWrReady = (count_r != CW'(DEPTH)) && (state_r < pkt_pkg::S_HUNT);
    if (hostWrValid && hostWrReady) begin
      pushEn = 1'b1;
    end
    if (hostRdReq && count_r != '0 && !txAct_r && !clr) begin
      popEn = 1'b1;  rdData_nxt = mem[rdPtr_r];  rdStb_nxt = 1'b1;
    end
    // buffer pointers; a clear empties everything
    rdPtr_nxt = popEn ? ((rdPtr_r == CW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1) : rdPtr_r;
    wrPtr_nxt = pushEn ? ((wrPtr_r == CW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1) : wrPtr_r;
    count_nxt = count_r + CW'(pushEn) - CW'(popEn);
    if (clr) begin
      rdPtr_nxt = '0;  wrPtr_nxt = '0;  count_nxt = '0;
    end
  end

  // engine and buffer registers
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= pkt_pkg::S_IDLE;  divCnt_r <= '0;  shReg_r <= '0;  bitCnt_r <= '0;
      byteCnt_r <= '0;  frameLen_r <= '0;  crc_r <= pkt_pkg::CRC_PRESET;  crcRx_r <= '0;
      lfsr_r <= pkt_pkg::WHITEN_SEED;  phase_r <= 1'b0;  firstChip_r <= 1'b0;
      syncSh_r <= '0;  txChip_r <= 1'b0;  txAct_r <= 1'b0;  txDone_r <= 1'b0;
      ready_r <= 1'b0;  match_r <= 1'b0;  pass_r <= 1'b0;  rdPtr_r <= '0;
      wrPtr_r <= '0;  count_r <= '0;  rdData_r <= '0;  rdStb_r <= 1'b0;
    end else begin
      state_r <= state_nxt;  divCnt_r <= divCnt_nxt;  shReg_r <= shReg_nxt;
      bitCnt_r <= bitCnt_nxt;  byteCnt_r <= byteCnt_nxt;  frameLen_r <= frameLen_nxt;
      crc_r <= crc_nxt;  crcRx_r <= crcRx_nxt;  lfsr_r <= lfsr_nxt;  phase_r <= phase_nxt;
      firstChip_r <= firstChip_nxt;  syncSh_r <= syncSh_nxt;  txChip_r <= txChip_nxt;
      txAct_r <= txAct_nxt;  txDone_r <= txDone_nxt;  ready_r <= ready_nxt;
      match_r <= match_nxt;  pass_r <= pass_nxt;  rdPtr_r <= rdPtr_nxt;
      wrPtr_r <= wrPtr_nxt;  count_r <= count_nxt;  rdData_r <= rdData_nxt;
      rdStb_r <= rdStb_nxt;
    end
  end

  // outputs
  assign lineTxChip   = txChip_r;
  assign lineTxActive = txAct_r;
  assign hostRdData   = rdData_r;
  assign hostRdStrobe = rdStb_r;
  assign statusFlags  = '{txDone_r, ready_r, pass_r, match_r,
                          count_r > levelThreshold, count_r == CW'(DEPTH), count_r != '0};

  // checks
  chk_buf_bound: assert property (@(posedge ref_clk) disable iff (sys_rst)
    count_r <= CW'(DEPTH)) else $error("buffer count above depth");
  chk_done_after_tail: assert property (@(posedge ref_clk) disable iff (sys_rst)
    txDone_r |-> $past(state_r) == pkt_pkg::S_TXEND && !txAct_r && $past(tick))
    else $error("done flag before final chip period");
  chk_nosync_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (state_r == pkt_pkg::S_HUNT && !syncHit) |=> !match_r && !ready_r)
    else $error("flag raised without sync");
  chk_sync_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
    syncHit |=> state_r == pkt_pkg::S_RXDATA && match_r == !$past(addrOn))
    else $error("sync did not start payload");
  chk_addr_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (addrEvt && !addrHit) |=> count_r == '0 && state_r == pkt_pkg::S_HUNT && !match_r)
    else $error("address mismatch not discarded");
  chk_len_drop: assert property (@(posedge ref_clk) disable iff (sys_rst)
    lenBad |=> count_r == '0 && state_r == pkt_pkg::S_HUNT)
    else $error("oversize length not discarded");
  chk_check_result: assert property (@(posedge ref_clk) disable iff (sys_rst)
    crcEvt |=> pass_r == $past(crcPass) && state_r == pkt_pkg::S_HUNT)
    else $error("check result not recorded");
  chk_fail_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (crcEvt && !crcPass && !frameConfig.keepOnCheckFail) |=> count_r == '0 && !ready_r)
    else $error("failed frame kept");
  chk_manch_pair: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (tick && manch && phase_r && state_r inside {pkt_pkg::S_TXDATA, pkt_pkg::S_TXCRC})
    |=> txChip_r == !$past(txChip_r)) else $error("manchester half not inverted");
endmodule : packet_filter_line_balance_select_codec
`default_nettype wire

// ==== rtl/pkt_pkg.sv ====
// shared constants and types for the frame filter and line codec
// assumes a single clock domain; all users reference pkt_pkg::name
package pkt_pkg;
  localparam int          BUF_DEPTH   = 66;       // payload buffer bytes
  localparam int          SYNC_BYTES  = 4;        // sync pattern length in bytes
  localparam logic [15:0] CRC_POLY    = 16'h1021; // x^16+x^12+x^5+1
  localparam logic [15:0] CRC_PRESET  = 16'h1d0f; // nonzero preset
  localparam logic [8:0]  WHITEN_SEED = 9'h1ff;   // all ones at payload start
  localparam int          WHITEN_TAP  = 5;        // x^9+x^5+1 feedback tap
  localparam logic [1:0]  BAL_MANCH   = 2'h1;     // line balance: manchester
  localparam logic [1:0]  BAL_WHITEN  = 2'h2;     // line balance: whitening
  localparam logic [1:0]  ADDR_OWN    = 2'h1;     // filter on own id
  localparam logic [1:0]  ADDR_GROUP  = 2'h2;     // filter on own or group id
  localparam logic [1:0]  FMT_FIXED   = 2'h0;     // fixed length frames
  localparam logic [1:0]  FMT_VAR     = 2'h1;     // length byte leads payload
  localparam logic [1:0]  FMT_UNLIM   = 2'h2;     // no length counting

  // static frame configuration
  typedef struct packed {
    logic [1:0] lineBalanceSelect;
    logic [1:0] frameFormat;
    logic [1:0] addrFilterSelect;
    logic       checkEnable;
    logic       keepOnCheckFail;
    logic [7:0] maxFrameLength;
    logic [7:0] ownStationId;
    logic [7:0] groupStationId;
  } frame_cfg_t;

  // status flags toward the host
  typedef struct packed {
    logic txDoneFlag;
    logic rxFrameReadyFlag;
    logic checkPassFlag;
    logic frameMatchFlag;
    logic bufferLevelFlag;
    logic bufferFullFlag;
    logic bufferNonemptyFlag;
  } flags_t;

  // frame engine states
  typedef enum logic [2:0] {
    S_IDLE, S_TXSYNC, S_TXDATA, S_TXCRC, S_TXEND, S_HUNT, S_RXDATA, S_RXCRC
  } eng_state_t;
endpackage : pkt_pkg

// ==== verif/frame_sender.sv ====
// peer radio model: codes a frame and shifts it onto the receive chip line
// assumes its chip divider restarts together with the block's on sys_rst
`timescale 1ns/10ps
`default_nettype none
module frame_sender #(
  parameter int          RATE = 7,             // chip period minus one
  parameter logic [31:0] SYNC = 32'h2dd4_6a93  // sync pattern without zero bytes
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  output logic      lineRxChip,
  output logic      tick
);
  int cnt;       // mirror of the chip divider
  bit chips[$];  // coded chips of the frame in hand
  bit live;      // raised by the bench to send the frame
  assign tick = (cnt == RATE);
  // new chip well ahead of the sampling tick; an idle line toggles every cycle
  always @(posedge ref_clk) begin
    cnt <= (sys_rst || tick) ? 0 : cnt + 1;
    if (sys_rst) begin
      lineRxChip <= 1'b0;
    end else if (live && cnt == 1) begin
      if (chips.size() > 0) lineRxChip <= chips.pop_front();
      else live <= 1'b0;
    end else if (!live) begin
      lineRxChip <= ~lineRxChip;
    end
  end
  // sync, then payload and inverted checksum, coded one way at most
  function automatic void build(input logic [7:0] b[$], input logic [1:0] bal,
                                input bit bad);
    logic [15:0] crc;
    logic [8:0]  lfsr;
    logic [7:0]  tail[$];
    bit          d;
    crc  = pkt_pkg::CRC_PRESET;
    lfsr = pkt_pkg::WHITEN_SEED;
    chips.delete();
    for (int i = 31; i >= 0; i--) chips.push_back(SYNC[i]);
    foreach (b[k]) for (int i = 7; i >= 0; i--)
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[k][i]) ? pkt_pkg::CRC_POLY : 16'h0000);
    tail = b;
    tail.push_back(~crc[15:8]);
    tail.push_back(~crc[7:0]);
    foreach (tail[k]) for (int i = 7; i >= 0; i--) begin
      d = tail[k][i];
      if (bal == pkt_pkg::BAL_WHITEN) begin
        d ^= lfsr[0];
        lfsr = {lfsr[0] ^ lfsr[pkt_pkg::WHITEN_TAP], lfsr[8:1]};
      end
      chips.push_back(d);
      if (bal == pkt_pkg::BAL_MANCH) chips.push_back(!d);
    end
    // a spoilt checksum chip, only when a scenario asks for it
    if (bad) chips[chips.size() - 2] = !chips[chips.size() - 2];
  endfunction : build
endmodule : frame_sender
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench: buffer limits, receive filtering table, coded transmit
// assumes the frame engine's own assertions sit inside the design files
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int RATE = 7;  // short chip period keeps runs brief
  logic                ref_clk = 1'b0;
  logic                sys_rst = 1'b1;
  pkt_pkg::frame_cfg_t cfg = '0;
  logic                txStart = 1'b0;
  logic                rxEnable = 1'b0;
  logic                hostWrValid = 1'b0;
  logic                hostRdReq = 1'b0;
  logic [7:0]          hostWrData = 8'h00;
  logic [7:0]          hostRdData;
  logic                hostWrReady, hostRdStrobe, lineRxChip, lineTxChip, lineTxActive, tick;
  pkt_pkg::flags_t     flags;
  int                  fail_count = 0;
  int                  cmp_count = 0;
  int                  k;
  logic [7:0]          q[$];
  bit                  got[$];
  bit                  seenM, seenR, t;
  always #12.5 ref_clk = ~ref_clk;
  packet_filter_line_balance_select_codec DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .frameConfig(cfg),
    .syncPatternBytes(32'h2dd4_6a93), .symbolRateSetting(16'h0007), .levelThreshold(7'h0a),
    .txStart(txStart), .rxEnable(rxEnable), .hostWrData(hostWrData), .hostWrValid(hostWrValid),
    .hostWrReady(hostWrReady), .hostRdReq(hostRdReq), .hostRdData(hostRdData),
    .hostRdStrobe(hostRdStrobe), .lineRxChip(lineRxChip), .lineTxChip(lineTxChip),
    .lineTxActive(lineTxActive), .statusFlags(flags));
  frame_sender #(.RATE(RATE)) PEER (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .lineRxChip(lineRxChip), .tick(tick));
  // verdict and end of run
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // one comparison, counted
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check
  // a used-up wait bound ends the run
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      final_report();
    end
  endtask : guard
  // push one byte into the buffer
  task automatic wr(input logic [7:0] d);
    @(negedge ref_clk);
    hostWrData = d;
    hostWrValid = 1'b1;
    @(negedge ref_clk);
    hostWrValid = 1'b0;
  endtask : wr
  // pop one byte; strobe and data stand in the following cycle
  task automatic rd(input logic [7:0] e);
    @(negedge ref_clk);
    hostRdReq = 1'b1;
    @(negedge ref_clk);
    hostRdReq = 1'b0;
    check(32'({hostRdStrobe, hostRdData}), 32'({1'b1, e}));
  endtask : rd
  // collect the event flags for one cycle
  task automatic sample;
    @(negedge ref_clk);
    seenM |= flags.frameMatchFlag;
    seenR |= flags.rxFrameReadyFlag;
  endtask : sample
  // receive one frame from the peer, then judge flags and buffer contents
  task automatic rx(input logic [1:0] fmt, sel, bal, input logic [7:0] mx,
                    input logic [31:0] d, input int n, input bit bad, keep, em, er, ep);
    @(negedge ref_clk);
    cfg.frameFormat = fmt;
    cfg.addrFilterSelect = sel;
    cfg.lineBalanceSelect = bal;
    cfg.maxFrameLength = mx;
    cfg.keepOnCheckFail = keep;
    rxEnable = 1'b1;
    q.delete();
    for (int i = n - 1; i >= 0; i--) q.push_back(d[8*i +: 8]);
    PEER.build(q, bal, bad);
    seenM = 1'b0;
    seenR = 1'b0;
    PEER.live = 1'b1;
    for (k = 0; PEER.live && k < 3000; k++) sample();
    guard(k, 3000);
    repeat (100) sample();
    rxEnable = 1'b0;
    check(32'({seenM, seenR}), 32'({em, er}));
    if (er) check(32'(flags.checkPassFlag), 32'(ep));
    for (int i = n - 1; i >= 0 && er; i--) rd(d[8*i +: 8]);
    check(32'(flags.bufferNonemptyFlag), 32'h0);
  endtask : rx
  // send the queued bytes as one frame and compare every chip on the line
  task automatic tx(input logic [1:0] fmt, bal, input logic [7:0] mx);
    cfg.frameFormat = fmt;
    cfg.maxFrameLength = mx;
    cfg.lineBalanceSelect = bal;
    got.delete();
    foreach (q[i]) wr(q[i]);
    PEER.build(q, bal, 1'b0);
    for (k = 0; k < 16 && tick !== 1'b1; k++) @(negedge ref_clk);
    guard(k, 16);
    @(negedge ref_clk);
    txStart = 1'b1;
    @(negedge ref_clk);
    txStart = 1'b0;
    for (k = 0; k < 3000 && lineTxActive === 1'b1; k++) begin
      t = tick;
      @(negedge ref_clk);
      if (t && lineTxActive === 1'b1) got.push_back(lineTxChip);
    end
    guard(k, 3000);
    check(32'(flags.txDoneFlag), 32'h0000_0001);
    check(32'(got.size()), 32'(PEER.chips.size()));
    foreach (got[i]) check(32'(got[i]), 32'(PEER.chips[i]));
  endtask : tx
  // main sequence
  initial begin
    cfg.ownStationId = 8'h5a;
    cfg.groupStationId = 8'ha5;
    cfg.checkEnable = 1'b1;
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    check(32'({flags, hostWrReady}), 32'h0000_0001);
    for (int i = 0; i < 66; i++) begin
      if (i == 10 || i == 11) check(32'(flags.bufferLevelFlag), 32'(i == 11));
      wr(8'(i + 1));
    end
    check(32'({flags.bufferFullFlag, hostWrReady}), 32'h0000_0002);
    wr(8'hee);
    for (int i = 0; i < 66; i++) rd(8'(i + 1));
    check(32'(flags.bufferNonemptyFlag), 32'h0000_0000);
    rx(pkt_pkg::FMT_VAR, pkt_pkg::ADDR_OWN, pkt_pkg::BAL_WHITEN, 8'h04, 32'h035a_1122, 4,
       0, 0, 1, 1, 1);
    rx(pkt_pkg::FMT_VAR, pkt_pkg::ADDR_OWN, pkt_pkg::BAL_MANCH, 8'h10, 32'h03a5_1122, 4,
       0, 0, 0, 0, 0);
    rx(pkt_pkg::FMT_VAR, pkt_pkg::ADDR_GROUP, pkt_pkg::BAL_MANCH, 8'hff, 32'h03a5_3344, 4,
       0, 0, 1, 1, 1);
    rx(pkt_pkg::FMT_FIXED, pkt_pkg::ADDR_OWN, 2'h0, 8'h03, 32'h005a_7788, 3,
       0, 0, 1, 1, 1);
    rx(pkt_pkg::FMT_VAR, 2'h0, 2'h0, 8'h04, 32'h0401_0203, 4, 0, 0, 1, 0, 0);
    rx(pkt_pkg::FMT_VAR, 2'h0, 2'h0, 8'h04, 32'h0301_0203, 4, 1, 0, 1, 0, 0);
    rx(pkt_pkg::FMT_VAR, 2'h0, 2'h0, 8'h04, 32'h0301_0203, 4, 1, 1, 1, 1, 0);
    q = {8'hc3, 8'h5a, 8'h0f};
    tx(pkt_pkg::FMT_FIXED, pkt_pkg::BAL_MANCH, 8'h03);
    q = {8'h02, 8'h5a, 8'h33};
    tx(pkt_pkg::FMT_VAR, pkt_pkg::BAL_WHITEN, 8'h10);
    final_report();
  end
endmodule : testbench
`default_nettype wire
